// File: dmad_defines.svh
// Encoding constants for the multiply/ALU instruction decoder.
// Assumes the core hands over a 16-bit word in this private encoding.
`ifndef DMAD_DEFINES_SVH
`define DMAD_DEFINES_SVH

// Common fields
`define DMAD_F_OP     15:11
`define DMAD_F_FORM   10:8
`define DMAD_F_CC     7:4
// Multiply fields
`define DMAD_F_S1IND  10
`define DMAD_F_BSW    9:8
`define DMAD_F_S1SEL  7:5
`define DMAD_F_S1BK   5
`define DMAD_F_S2N    4:3
`define DMAD_F_S2BK   2
`define DMAD_F_LOOP   1:0

// Opcodes
`define DMAD_OP_NOP   5'h00
`define DMAD_OP_MLD   5'h01
`define DMAD_OP_MULTIPLY_ACCUMULATE_ADD_OP  5'h02
`define DMAD_OP_MULTIPLY_ACCUMULATE_SUB_OP  5'h03
`define DMAD_OP_NEG   5'h04
`define DMAD_OP_OR    5'h05
`define DMAD_OP_XOR   5'h06
`define DMAD_OP_SUB   5'h07
`define DMAD_OP_PUSH  5'h08
`define DMAD_OP_POP   5'h09
`define DMAD_OP_RET   5'h0a
`define DMAD_OP_RL    5'h0b
`define DMAD_OP_RR    5'h0c
`define DMAD_OP_SLL   5'h0d
`define DMAD_OP_SRA   5'h0e
`define DMAD_OP_SCF   5'h0f
`define DMAD_OP_SET_IRQ_ENABLE_OP  5'h10
`define DMAD_OP_SET_USER_OUTPUT_FLAG_OP  5'h11

// Source forms
`define DMAD_FM_LIMM  3'h2
`define DMAD_FM_MEMI  3'h3
`define DMAD_PU_LIMM  3'h4
`define DMAD_PU_ACCI  3'h5
`define DMAD_PU_MEMI  3'h6

// Bank switch, loop modifier, hardware register codes
`define DMAD_BSW_DFLT 2'h0
`define DMAD_BSW_RSV  2'h1
`define DMAD_BSW_OFF  2'h2
`define DMAD_BSW_ON   2'h3
`define DMAD_LP_DEC   2'h1
`define DMAD_LP_INC   2'h2
`define DMAD_LP_RSV   2'h3
`define DMAD_HW_X     3'h0

// Condition codes
`define DMAD_CC_T     4'h0
`define DMAD_CC_C     4'h1
`define DMAD_CC_NC    4'h2
`define DMAD_CC_Z     4'h3
`define DMAD_CC_NZ    4'h4
`define DMAD_CC_MI    4'h5
`define DMAD_CC_PL    4'h6
`define DMAD_CC_IE    4'h7
`define DMAD_CC_NIE   4'h8
`define DMAD_CC_U1    4'h9
`define DMAD_CC_NU1   4'ha

// Words and cycles
`define DMAD_W1       2'h1
`define DMAD_W2       2'h2
`define DMAD_C1       2'h1
`define DMAD_C2       2'h2
`define DMAD_C3       2'h3
`define DMAD_CNT0     2'h0

// Stack and reset values
`define DMAD_STK_D    4
`define DMAD_SP_FULL  3'h4
`define DMAD_SP_0     3'h0
`define DMAD_SP_1     3'h1
`define DMAD_W16_0    16'h0000
`endif

// File: dmad_pkg.sv
// Types shared by the decoder core and its helpers.
// Holds no constants; encodings live in the defines header.
package dmad_pkg;
   typedef struct packed {
      logic c;
      logic z;
      logic n;
      logic ie;
      logic op;
   } dmad_flags_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
      logic [15:0] imm;
   } dmad_instr_s;

   typedef struct packed {
      logic [15:0] src1;
      logic [15:0] src2;
   } dmad_opnd_s;

   typedef struct packed {
      logic [15:0] acc;
      logic [31:0] prod;
      dmad_flags_s flags;
      logic        bank;
      logic [1:0]  words;
      logic [1:0]  cycles;
      logic        illegal;
      logic        done;
   } dmad_res_s;

   typedef struct packed {
      logic       stb;
      logic       dec;
      logic [1:0] n;
      logic       bank;
   } dmad_ptr_s;
endpackage

// File: dmad_cond.sv
// Condition code evaluator against the current status flags.
// Purely combinational; unknown codes (including false) never hold.
`timescale 1ns/10ps
`include "dmad_defines.svh"
module dmad_cond import dmad_pkg::*; (
   input  wire logic [3:0]  cc_in,
   input  wire dmad_flags_s flags_in,
   output logic             ok_out
);
   // One term per code
   always_comb begin
      unique case (cc_in)
         `DMAD_CC_T:   ok_out = 1'b1;
         `DMAD_CC_C:   ok_out = flags_in.c;
         `DMAD_CC_NC:  ok_out = !flags_in.c;
         `DMAD_CC_Z:   ok_out = flags_in.z;
         `DMAD_CC_NZ:  ok_out = !flags_in.z;
         `DMAD_CC_MI:  ok_out = flags_in.n;
         `DMAD_CC_PL:  ok_out = !flags_in.n;
         `DMAD_CC_IE:  ok_out = flags_in.ie;
         `DMAD_CC_NIE: ok_out = !flags_in.ie;
         `DMAD_CC_U1:  ok_out = flags_in.op;
         `DMAD_CC_NU1: ok_out = !flags_in.op;
         default:      ok_out = 1'b0;
      endcase
   end
endmodule

// File: dmad_mulchk.sv
// Operand checks for the three multiply instructions.
// Combinational; the core gates the result with its own take strobe.
`timescale 1ns/10ps
`include "dmad_defines.svh"
module dmad_mulchk (
   input  wire logic [15:0] word_in,
   input  wire logic        mul_in,
   output logic             bad_out,
   output logic             bsw_on_out
);
   logic ind;
   logic [1:0] bsw;

   assign ind = word_in[`DMAD_F_S1IND];
   assign bsw = word_in[`DMAD_F_BSW];

   // Bank 1 for indirect src1, bank 0 for src2, no X as src1
   assign bad_out = mul_in &
      ((ind & !word_in[`DMAD_F_S1BK]) |
       (!ind & (word_in[`DMAD_F_S1SEL] == `DMAD_HW_X)) |
       word_in[`DMAD_F_S2BK] |
       (bsw == `DMAD_BSW_RSV) |
       (word_in[`DMAD_F_LOOP] == `DMAD_LP_RSV));

   // Omitted switch follows the operand form
   assign bsw_on_out = (bsw == `DMAD_BSW_ON) |
      ((bsw == `DMAD_BSW_DFLT) & ind);
endmodule

// File: dmad_core.sv
// Decode and execute core for multiply, ALU, stack and flag instructions.
// Assumes the core fetches the second word into imm and supplies operands.
`timescale 1ns/10ps
`include "dmad_defines.svh"
module dmad_core import dmad_pkg::*; (
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   input  wire dmad_instr_s instr_in,
   input  wire dmad_opnd_s  opnd_in,
   output logic             ready_out,
   output dmad_res_s        res_out,
   output dmad_ptr_s        ptr_out,
   output logic             pc_load_out,
   output logic [15:0]      pc_out,
   output logic [15:0]      pop_data_out,
   output logic             pop_stb_out
);
   dmad_res_s   res_q, res_d;
   dmad_ptr_s   ptr_q, ptr_d;
   logic        ready_q, ready_d;
   logic [1:0]  cnt_q, cnt_d;
   logic        pc_ld_q, pc_ld_d;
   logic [15:0] pc_q, pc_d;
   logic [15:0] pop_q, pop_d;
   logic        pop_stb_q, pop_stb_d;
   logic [15:0] stk_q [`DMAD_STK_D];
   logic [15:0] stk_d [`DMAD_STK_D];
   logic [2:0]  sp_q, sp_d;

   logic [15:0] w;
   logic [4:0]  op;
   logic [2:0]  form;
   logic        take;
   logic        is_mul;
   logic        is_alu;
   logic        cc_op;
   logic [3:0]  cc_eff;
   logic        cond_ok;
   logic        mul_bad;
   logic        bsw_on;
   logic        bad;
   logic        exec;
   logic [1:0]  words;
   logic [1:0]  cyc;
   logic [31:0] prod_w;
   logic [16:0] diff_w;
   logic [1:0]  top;

   assign w      = instr_in.word;
   assign op     = w[`DMAD_F_OP];
   assign form   = w[`DMAD_F_FORM];
   assign take   = instr_in.valid & ready_q;
   assign is_mul = (op == `DMAD_OP_MLD) | (op == `DMAD_OP_MULTIPLY_ACCUMULATE_ADD_OP) |
                   (op == `DMAD_OP_MULTIPLY_ACCUMULATE_SUB_OP);
   assign is_alu = (op == `DMAD_OP_OR) | (op == `DMAD_OP_XOR) |
                   (op == `DMAD_OP_SUB);
   assign cc_op  = (op == `DMAD_OP_NEG) | (op == `DMAD_OP_RL) |
                   (op == `DMAD_OP_RR) | (op == `DMAD_OP_SLL) |
                   (op == `DMAD_OP_SRA);
   // Only negate, rotate and shift ops honour the cc field; others always run
   assign cc_eff = cc_op ? w[`DMAD_F_CC] : `DMAD_CC_T;
   assign top    = 2'(sp_q - `DMAD_SP_1);
   assign prod_w = 32'($signed(opnd_in.src1)) *
                   32'($signed(opnd_in.src2));
   assign diff_w = {1'b0, res_q.acc} - {1'b0, opnd_in.src1};

   dmad_cond u_cond (
      .cc_in    (cc_eff),
      .flags_in (res_q.flags),
      .ok_out   (cond_ok)
   );

   dmad_mulchk u_mulchk (
      .word_in    (w),
      .mul_in     (is_mul),
      .bad_out    (mul_bad),
      .bsw_on_out (bsw_on)
   );

   // Illegal words never touch state; stack faults count as illegal
   always_comb begin
      bad = mul_bad;
      if (op > `DMAD_OP_SET_USER_OUTPUT_FLAG_OP) begin
         bad = 1'b1;
      end
      if ((op == `DMAD_OP_PUSH) && (sp_q == `DMAD_SP_FULL)) begin
         bad = 1'b1;
      end
      if (((op == `DMAD_OP_POP) || (op == `DMAD_OP_RET)) &&
          (sp_q == `DMAD_SP_0)) begin
         bad = 1'b1;
      end
   end

   assign exec = take & !bad & cond_ok;

   // Word and cycle cost per opcode and source form
   always_comb begin
      words = `DMAD_W1;
      cyc   = `DMAD_C1;
      if (is_alu && (form == `DMAD_FM_LIMM)) begin
         words = `DMAD_W2;
         cyc   = `DMAD_C2;
      end
      if (is_alu && (form == `DMAD_FM_MEMI)) begin
         cyc = `DMAD_C3;
      end
      if ((op == `DMAD_OP_PUSH) && (form == `DMAD_PU_LIMM)) begin
         words = `DMAD_W2;
         cyc   = `DMAD_C2;
      end
      if ((op == `DMAD_OP_PUSH) && ((form == `DMAD_PU_ACCI) ||
          (form == `DMAD_PU_MEMI))) begin
         cyc = `DMAD_C3;
      end
      if (op == `DMAD_OP_RET) begin
         cyc = `DMAD_C2;
      end
   end

   // Next state: execution happens on the take edge, the counter only
   // holds off the next word, so results appear one edge after take
   always_comb begin
      res_d     = res_q;
      res_d.done = 1'b0;
      ptr_d     = '0;
      ready_d   = ready_q;
      cnt_d     = cnt_q;
      pc_ld_d   = 1'b0;
      pc_d      = pc_q;
      pop_d     = pop_q;
      pop_stb_d = 1'b0;
      stk_d     = stk_q;
      sp_d      = sp_q;
      if (take) begin
         res_d.words   = words;
         res_d.cycles  = cyc;
         res_d.illegal = bad;
         cnt_d   = 2'(cyc - `DMAD_C1);
         ready_d = (cyc == `DMAD_C1);
         res_d.done = (cyc == `DMAD_C1);
      end else if (cnt_q != `DMAD_CNT0) begin
         cnt_d   = 2'(cnt_q - `DMAD_C1);
         ready_d = (cnt_q == `DMAD_C1);
         res_d.done = (cnt_q == `DMAD_C1);
      end
      if (exec) begin
         unique case (op)
            `DMAD_OP_MLD, `DMAD_OP_MULTIPLY_ACCUMULATE_ADD_OP, `DMAD_OP_MULTIPLY_ACCUMULATE_SUB_OP: begin
               if (op == `DMAD_OP_MULTIPLY_ACCUMULATE_ADD_OP) begin
                  res_d.acc = res_q.acc + res_q.prod[31:16];
               end else if (op == `DMAD_OP_MULTIPLY_ACCUMULATE_SUB_OP) begin
                  res_d.acc = res_q.acc - res_q.prod[31:16];
               end
               res_d.prod = prod_w;
               if (bsw_on) begin
                  res_d.bank = !res_q.bank;
               end
               // Pointer post-adjust on the second source
               ptr_d.stb  = (w[`DMAD_F_LOOP] != 2'h0);
               ptr_d.dec  = (w[`DMAD_F_LOOP] == `DMAD_LP_DEC);
               ptr_d.n    = w[`DMAD_F_S2N];
               ptr_d.bank = w[`DMAD_F_S2BK];
            end
            `DMAD_OP_NEG: begin
               res_d.acc = 16'(-res_q.acc);
            end
            `DMAD_OP_OR: begin
               res_d.acc = res_q.acc | opnd_in.src1;
            end
            `DMAD_OP_XOR: begin
               res_d.acc = res_q.acc ^ opnd_in.src1;
            end
            `DMAD_OP_SUB: begin
               res_d.acc     = diff_w[15:0];
               res_d.flags.c = diff_w[16];
            end
            `DMAD_OP_PUSH: begin
               stk_d[sp_q[1:0]] = (form == `DMAD_PU_LIMM) ?
                                  instr_in.imm : opnd_in.src1;
               sp_d = sp_q + `DMAD_SP_1;
            end
            `DMAD_OP_POP: begin
               pop_d     = stk_q[top];
               pop_stb_d = 1'b1;
               sp_d      = sp_q - `DMAD_SP_1;
            end
            `DMAD_OP_RET: begin
               pc_d    = stk_q[top];
               pc_ld_d = 1'b1;
               sp_d    = sp_q - `DMAD_SP_1;
            end
            `DMAD_OP_RL: begin
               res_d.acc = {res_q.acc[14:0], res_q.acc[15]};
               res_d.flags.c = res_q.acc[15];
            end
            `DMAD_OP_RR: begin
               res_d.acc = {res_q.acc[0], res_q.acc[15:1]};
               res_d.flags.c = res_q.acc[0];
            end
            `DMAD_OP_SLL: begin
               res_d.acc = {res_q.acc[14:0], 1'b0};
               res_d.flags.c = res_q.acc[15];
            end
            `DMAD_OP_SRA: begin
               res_d.acc = {res_q.acc[15], res_q.acc[15:1]};
               res_d.flags.c = res_q.acc[0];
            end
            `DMAD_OP_SCF: begin
               res_d.flags.c = 1'b1;
            end
            `DMAD_OP_SET_IRQ_ENABLE_OP: begin
               res_d.flags.ie = 1'b1;
            end
            `DMAD_OP_SET_USER_OUTPUT_FLAG_OP: begin
               res_d.flags.op = 1'b1;
            end
            default: begin
            end
         endcase
         res_d.flags.z = (res_d.acc == `DMAD_W16_0);
         res_d.flags.n = res_d.acc[15];
      end
   end

   // Registers; the stack array has no reset, sp marks what is valid
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         res_q     <= '0;
         ptr_q     <= '0;
         ready_q   <= 1'b1;
         cnt_q     <= `DMAD_CNT0;
         pc_ld_q   <= 1'b0;
         pc_q      <= `DMAD_W16_0;
         pop_q     <= `DMAD_W16_0;
         pop_stb_q <= 1'b0;
         sp_q      <= `DMAD_SP_0;
      end else begin
         res_q     <= res_d;
         ptr_q     <= ptr_d;
         ready_q   <= ready_d;
         cnt_q     <= cnt_d;
         pc_ld_q   <= pc_ld_d;
         pc_q      <= pc_d;
         pop_q     <= pop_d;
         pop_stb_q <= pop_stb_d;
         sp_q      <= sp_d;
      end
      stk_q <= stk_d;
   end

   assign ready_out    = ready_q;
   assign res_out      = res_q;
   assign ptr_out      = ptr_q;
   assign pc_load_out  = pc_ld_q;
   assign pc_out       = pc_q;
   assign pop_data_out = pop_q;
   assign pop_stb_out  = pop_stb_q;

   // Checks on decode and timing
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);

   mul_src1_bank_a: assert property (take && is_mul &&
      w[`DMAD_F_S1IND] && !w[`DMAD_F_S1BK] |=> res_out.illegal)
      else $error("indirect src1 outside bank 1 accepted");
   mul_src2_bank_a: assert property (take && is_mul &&
      w[`DMAD_F_S2BK] |=> res_out.illegal && $stable(res_out.prod))
      else $error("src2 outside bank 0 accepted");
   mul_no_x_a: assert property (take && is_mul &&
      !w[`DMAD_F_S1IND] && (w[`DMAD_F_S1SEL] == `DMAD_HW_X)
      |=> res_out.illegal)
      else $error("X accepted as multiply src1");
   bsw_dflt_off_a: assert property (exec && is_mul &&
      !w[`DMAD_F_S1IND] && (w[`DMAD_F_BSW] == `DMAD_BSW_DFLT)
      |=> $stable(res_out.bank))
      else $error("default switch not off");
   bsw_dflt_on_a: assert property (exec && is_mul &&
      w[`DMAD_F_S1IND] && (w[`DMAD_F_BSW] == `DMAD_BSW_DFLT)
      |=> res_out.bank != $past(res_out.bank))
      else $error("default switch not on");
   mul_one_cyc_a: assert property (take && is_mul && !bad
      |=> res_out.done && ready_out && res_out.words == `DMAD_W1)
      else $error("multiply not one word one cycle");
   ret_two_cyc_a: assert property (exec && op == `DMAD_OP_RET
      |=> pc_load_out && !ready_out ##1 ready_out && res_out.done)
      else $error("return timing wrong");
   alu_memi_cyc_a: assert property (take && is_alu &&
      form == `DMAD_FM_MEMI |=> !ready_out [*2] ##1 ready_out)
      else $error("memory indirect not three cycles");
   scf_sets_a: assert property (exec && op == `DMAD_OP_SCF
      |=> res_out.flags.c && res_out.done)
      else $error("carry not set");
   sra_shift_a: assert property (exec && op == `DMAD_OP_SRA
      |=> res_out.acc == {$past(res_out.acc[15]),
                          $past(res_out.acc[15:1])})
      else $error("arithmetic shift wrong");
   push_grows_a: assert property (exec && op == `DMAD_OP_PUSH
      |=> sp_q == 3'($past(sp_q) + `DMAD_SP_1))
      else $error("push did not grow stack");
   neg_value_a: assert property (exec && op == `DMAD_OP_NEG
      |=> res_out.acc == 16'(-$past(res_out.acc)))
      else $error("negate wrong");
   cond_skip_a: assert property (take && cc_op && !cond_ok
      |=> $stable(res_out.acc) && $stable(res_out.flags))
      else $error("false condition changed state");
   loop_dec_a: assert property (exec && is_mul &&
      w[`DMAD_F_LOOP] == `DMAD_LP_DEC |=> ptr_out.stb && ptr_out.dec)
      else $error("loop decrement missing");

   multiply_accumulate_add_op_cov: cover property (exec && op == `DMAD_OP_MULTIPLY_ACCUMULATE_ADD_OP);
   ret_cov:  cover property (exec && op == `DMAD_OP_RET);
   skip_cov: cover property (take && cc_op && !cond_ok);
   ill_cov:  cover property (take && mul_bad);
endmodule

// File: tb.sv
// Self-checking bench for the multiply/ALU decode and execute core.
// Assumes tb is the top; the core's assertions live in the design files.
`timescale 1ns/10ps
`include "dmad_defines.svh"
module tb import dmad_pkg::*;;
   typedef struct packed {
      logic [15:0] w;
      logic [1:0]  wd;
      logic [1:0]  cy;
      logic        il;
   } dmad_row_s;

   logic        clk_sys_in = 1'b0;
   logic        nrst_in    = 1'b0;
   dmad_instr_s instr      = '0;
   dmad_opnd_s  opnd       = '0;
   logic        ready_out;
   dmad_res_s   res_out;
   dmad_ptr_s   ptr_out;
   logic        pc_load_out;
   logic [15:0] pc_out;
   logic [15:0] pop_data_out;
   logic        pop_stb_out;
   int          miscompares = 0;
   int          comparisons = 0;
   int          ticks       = 0;
   logic [1:0]  lat;
   logic        pcl;
   logic        pst;
   logic        b;
   logic        nb;
   logic [15:0] a;
   logic [15:0] e;
   dmad_row_s   rows [0:27];
   logic [3:0]  ccs [0:9];

   dmad_core dut_u (
      .clk_sys_in   (clk_sys_in),
      .nrst_in      (nrst_in),
      .instr_in     (instr),
      .opnd_in      (opnd),
      .ready_out    (ready_out),
      .res_out      (res_out),
      .ptr_out      (ptr_out),
      .pc_load_out  (pc_load_out),
      .pc_out       (pc_out),
      .pop_data_out (pop_data_out),
      .pop_stb_out  (pop_stb_out)
   );

   // 25 MHz system clock
   always #20 clk_sys_in = ~clk_sys_in;

   // Hang guard: the whole run needs under a hundred cycles
   always @(posedge clk_sys_in) begin
      ticks++;
      if (ticks == 5000) begin
         miscompares++;
         test_done();
      end
   end

   // Plain opcode/form/condition word
   function automatic logic [15:0] mk(input logic [4:0] op,
         input logic [2:0] fm, input logic [3:0] cc);
      return {op, fm, cc, 4'h0};
   endfunction

   // Multiply word: indirect flag, switch, source 1 select, pointer n,
   // source 2 bank, loop modifier
   function automatic logic [15:0] mm(input logic [4:0] op,
         input logic ind, input logic [1:0] bsw, input logic [2:0] sel,
         input logic [1:0] n, input logic bk, input logic [1:0] lp);
      return {op, ind, bsw, sel, n, bk, lp};
   endfunction

   task automatic chk(input string nm, input logic [31:0] ex,
         input logic [31:0] got);
      comparisons++;
      if (got !== ex) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", nm, ex, got);
      end
   endtask

   // Issue one instruction and count edges from take to the done pulse;
   // pulses that stand one cycle are collected on the way
   task automatic run(input logic [15:0] w, input logic [15:0] imm,
         input logic [15:0] s1);
      int k;
      k = 0;
      while (ready_out !== 1'b1 && k < 20) begin
         @(posedge clk_sys_in);
         #1;
         k++;
      end
      instr = '{1'b1, w, imm};
      opnd  = '{s1, s1};
      @(posedge clk_sys_in);
      #1;
      // A one-cycle word keeps valid up, so the caller's next word follows
      // without a second assignment of valid in this time step
      if (ready_out !== 1'b1) begin
         instr.valid = 1'b0;
      end
      k = 1;
      pcl = (pc_load_out === 1'b1);
      pst = (pop_stb_out === 1'b1);
      while (res_out.done !== 1'b1 && k < 3) begin
         @(posedge clk_sys_in);
         #1;
         k++;
         pcl = pcl | (pc_load_out === 1'b1);
         pst = pst | (pop_stb_out === 1'b1);
      end
      lat = (res_out.done === 1'b1) ? 2'(k) : 2'h0;
   endtask

   // Words and cycles reported, and cycles actually taken
   task automatic cost(input logic [1:0] wd, input logic [1:0] cy);
      chk("words", wd, res_out.words);
      chk("cycles", cy, res_out.cycles);
      chk("latency", cy, lat);
   endtask

   task automatic test_done;
      $display("comparisons %0d miscompares %0d", comparisons,
               miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      // Cost table: word, words, cycles, refused
      rows = '{
         '{mk(`DMAD_OP_SUB, `DMAD_FM_LIMM, 4'h0), 2'h2, 2'h2, 1'h0},
         '{mk(`DMAD_OP_SUB, `DMAD_FM_MEMI, 4'h0), 2'h1, 2'h3, 1'h0},
         '{mk(`DMAD_OP_SUB, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_OR, `DMAD_FM_LIMM, 4'h0), 2'h2, 2'h2, 1'h0},
         '{mk(`DMAD_OP_OR, `DMAD_FM_MEMI, 4'h0), 2'h1, 2'h3, 1'h0},
         '{mk(`DMAD_OP_OR, 3'h1, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_XOR, `DMAD_FM_LIMM, 4'h0), 2'h2, 2'h2, 1'h0},
         '{mk(`DMAD_OP_XOR, `DMAD_FM_MEMI, 4'h0), 2'h1, 2'h3, 1'h0},
         '{mk(`DMAD_OP_XOR, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_NOP, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_RL, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_RR, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_SLL, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_SRA, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_NEG, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mm(`DMAD_OP_MLD, 1'h0, 2'h0, 3'h1, 2'h0, 1'h0, 2'h0),
           2'h1, 2'h1, 1'h0},
         '{mm(`DMAD_OP_MULTIPLY_ACCUMULATE_ADD_OP, 1'h1, 2'h0, 3'h1, 2'h1, 1'h0, 2'h0),
           2'h1, 2'h1, 1'h0},
         '{mm(`DMAD_OP_MULTIPLY_ACCUMULATE_SUB_OP, 1'h0, 2'h2, 3'h2, 2'h0, 1'h0, 2'h1),
           2'h1, 2'h1, 1'h0},
         '{mm(`DMAD_OP_MLD, 1'h0, 2'h0, 3'h0, 2'h0, 1'h0, 2'h0),
           2'h1, 2'h1, 1'h1},
         '{mm(`DMAD_OP_MULTIPLY_ACCUMULATE_ADD_OP, 1'h1, 2'h0, 3'h0, 2'h0, 1'h0, 2'h0),
           2'h1, 2'h1, 1'h1},
         '{mm(`DMAD_OP_MULTIPLY_ACCUMULATE_SUB_OP, 1'h0, 2'h0, 3'h1, 2'h0, 1'h1, 2'h0),
           2'h1, 2'h1, 1'h1},
         '{mm(`DMAD_OP_MLD, 1'h0, 2'h1, 3'h1, 2'h0, 1'h0, 2'h0),
           2'h1, 2'h1, 1'h1},
         '{mm(`DMAD_OP_MLD, 1'h0, 2'h0, 3'h1, 2'h0, 1'h0, 2'h3),
           2'h1, 2'h1, 1'h1},
         '{mm(`DMAD_OP_MULTIPLY_ACCUMULATE_SUB_OP, 1'h1, 2'h3, 3'h1, 2'h2, 1'h0, 2'h2),
           2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_SET_IRQ_ENABLE_OP, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_SET_USER_OUTPUT_FLAG_OP, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_NOP, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0},
         '{mk(`DMAD_OP_SCF, 3'h0, 4'h0), 2'h1, 2'h1, 1'h0}
      };
      ccs = '{`DMAD_CC_C, `DMAD_CC_NC, `DMAD_CC_MI, `DMAD_CC_PL,
              `DMAD_CC_Z, `DMAD_CC_NZ, `DMAD_CC_NIE, `DMAD_CC_IE,
              `DMAD_CC_NU1, `DMAD_CC_U1};
      // Reset for four cycles, released just after an edge
      repeat (4) @(posedge clk_sys_in);
      #1;
      nrst_in = 1'b1;
      chk("ready", 1'h1, ready_out);
      chk("acc", 32'h0, res_out.acc);
      chk("bank", 1'h0, res_out.bank);
      chk("done", 1'h0, res_out.done);
      // Back-to-back walk through the cost table
      foreach (rows[i]) begin
         run(rows[i].w, 16'h0003, 16'h0005);
         cost(rows[i].wd, rows[i].cy);
         chk("illegal", rows[i].il, res_out.illegal);
      end
      chk("flags", 5'h13, res_out.flags);
      // Bank switch defaults and explicit settings
      b = res_out.bank;
      nb = ~b;
      run(mm(`DMAD_OP_MLD, 1'h0, 2'h0, 3'h1, 2'h0, 1'h0, 2'h0), 16'h0,
          16'h0003);
      chk("product", 32'h9, res_out.prod);
      chk("bank", b, res_out.bank);
      run(mm(`DMAD_OP_MLD, 1'h0, 2'h3, 3'h1, 2'h0, 1'h0, 2'h0), 16'h0,
          16'h0003);
      chk("bank", nb, res_out.bank);
      run(mm(`DMAD_OP_MLD, 1'h1, 2'h0, 3'h1, 2'h0, 1'h0, 2'h0), 16'h0,
          16'h0003);
      chk("bank", b, res_out.bank);
      run(mm(`DMAD_OP_MLD, 1'h1, 2'h2, 3'h1, 2'h0, 1'h0, 2'h0), 16'h0,
          16'h0003);
      chk("bank", b, res_out.bank);
      // Refused multiply must leave product and bank alone
      run(mm(`DMAD_OP_MLD, 1'h1, 2'h3, 3'h1, 2'h0, 1'h1, 2'h0), 16'h0,
          16'h0007);
      chk("illegal", 1'h1, res_out.illegal);
      chk("bank", b, res_out.bank);
      chk("product", 32'h9, res_out.prod);
      // Loop modifiers on the second source pointer
      run(mm(`DMAD_OP_MLD, 1'h0, 2'h0, 3'h1, 2'h2, 1'h0, 2'h1), 16'h0,
          16'h0003);
      chk("ptr", 5'h1c, ptr_out);
      run(mm(`DMAD_OP_MULTIPLY_ACCUMULATE_ADD_OP, 1'h0, 2'h0, 3'h1, 2'h1, 1'h0, 2'h2), 16'h0,
          16'h0003);
      chk("ptr", 5'h12, ptr_out);
      // Negate and shifts, one with a false condition
      a = res_out.acc;
      e = 16'h0 - a;
      run(mk(`DMAD_OP_NEG, 3'h0, `DMAD_CC_T), 16'h0, 16'h0);
      chk("acc", e, res_out.acc);
      run(mk(`DMAD_OP_NEG, 3'h0, 4'hb), 16'h0, 16'h0);
      chk("acc", e, res_out.acc);
      chk("latency", 2'h1, lat);
      chk("illegal", 1'h0, res_out.illegal);
      run(mk(`DMAD_OP_SLL, 3'h0, `DMAD_CC_T), 16'h0, 16'h0);
      e = {e[14:0], 1'b0};
      chk("acc", e, res_out.acc);
      run(mk(`DMAD_OP_SRA, 3'h0, `DMAD_CC_T), 16'h0, 16'h0);
      chk("acc", {e[15], e[15:1]}, res_out.acc);
      // Condition codes in fail/hold pairs on known flags: c=0, z=0,
      // ie=1, op=1, and n following the sign of the negated value
      e = {e[15], e[15:1]};
      foreach (ccs[i]) begin
         run(mk(`DMAD_OP_NEG, 3'h0, ccs[i]), 16'h0, 16'h0);
         if (i % 2 == 1) begin
            e = 16'h0 - e;
         end
         chk("acc", e, res_out.acc);
      end
      chk("flags", 5'h03, res_out.flags);
      // Stack: fill to refusal, drain, return, return on empty
      run(mk(`DMAD_OP_PUSH, `DMAD_PU_LIMM, 4'h0), 16'h1234, 16'h0);
      cost(2'h2, 2'h2);
      run(mk(`DMAD_OP_PUSH, `DMAD_PU_ACCI, 4'h0), 16'h0, 16'h0);
      cost(2'h1, 2'h3);
      run(mk(`DMAD_OP_PUSH, `DMAD_PU_MEMI, 4'h0), 16'h0, 16'h0);
      cost(2'h1, 2'h3);
      run(mk(`DMAD_OP_PUSH, 3'h0, 4'h0), 16'h0, 16'h00a5);
      chk("illegal", 1'h0, res_out.illegal);
      run(mk(`DMAD_OP_PUSH, 3'h0, 4'h0), 16'h0, 16'h0bad);
      chk("illegal", 1'h1, res_out.illegal);
      run(mk(`DMAD_OP_POP, 3'h0, 4'h0), 16'h0, 16'h0);
      chk("pop strobe", 1'h1, pst);
      chk("pop data", 16'h00a5, pop_data_out);
      repeat (2) run(mk(`DMAD_OP_POP, 3'h0, 4'h0), 16'h0, 16'h0);
      run(mk(`DMAD_OP_RET, 3'h0, 4'h0), 16'h0, 16'h0);
      cost(2'h1, 2'h2);
      chk("pc load", 1'h1, pcl);
      chk("pc", 16'h1234, pc_out);
      run(mk(`DMAD_OP_RET, 3'h0, 4'h0), 16'h0, 16'h0);
      chk("illegal", 1'h1, res_out.illegal);
      // Second reset in mid-run
      instr.valid = 1'b0;
      nrst_in = 1'b0;
      @(posedge clk_sys_in);
      #1;
      nrst_in = 1'b1;
      chk("acc", 32'h0, res_out.acc);
      chk("ready", 1'h1, ready_out);
      test_done();
   end
endmodule
